// ==== design/mcd_pkg.sv ====
// Constants and carrier types for the memory range chip-select decoders
package mcd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Indexed configuration port pair
  localparam logic [15:0] INDEX_PORT = 16'h0022;
  localparam logic [15:0] DATA_PORT = 16'h0023;

  // Register indexes
  localparam logic [7:0] IDX_PIN_MAP = 8'h00B3;
  localparam logic [7:0] IDX_THREE_UPPER = 8'h00B9;
  localparam logic [7:0] IDX_THREE_MASK = 8'h00BA;
  localparam logic [7:0] IDX_FOUR_UPPER = 8'h00BB;
  localparam logic [7:0] IDX_FOUR_MASK = 8'h00BC;
  localparam logic [7:0] IDX_QUAL = 8'h00BD;
  localparam logic [7:0] IDX_ACT_EN = 8'h0060;

  // Values after reset
  localparam logic [7:0] RST_INDEX = 8'h0000;
  localparam logic [7:0] RST_PIN_MAP = 8'h00FF;
  localparam logic [7:0] RST_UPPER = 8'h0000;
  localparam logic [7:0] RST_MASK = 8'h0000;
  localparam logic [7:0] RST_QUAL = 8'h0000;
  localparam logic [1:0] RST_ACT_EN = 2'h0;

  // Field positions
  localparam int FOUR_WIDTH_BIT = 7;
  localparam int THREE_WIDTH_BIT = 3;
  localparam int ACT_FOUR_BIT = 3;
  localparam int ACT_THREE_BIT = 2;

  // Qualifier codes; the others are reserved and never hit
  localparam logic [2:0] Q_ADDR_ONLY = 3'h0;
  localparam logic [2:0] Q_READ = 3'h1;
  localparam logic [2:0] Q_WRITE = 3'h2;
  localparam logic [2:0] Q_EITHER = 3'h3;
  localparam logic [2:0] Q_CPU_VALID = 3'h4;

  // Pin mapping
  localparam int NUM_PINS = 15;
  localparam logic [3:0] PIN_DISABLED = 4'hF;

  ////////////////////////////////////////////////////////////////////////////
  // ISA memory cycle as seen by the decoders
  typedef struct packed {
    logic [25:14] sa;
    logic memr_n;
    logic memw_n;
    logic cpu_addr_valid;
    logic mcs16_n;
  } mcd_isa_type;

  // Settings of one range decoder
  typedef struct packed {
    logic [7:0] upper;
    logic [3:0] compare;
    logic [3:0] low_match;
    logic wide_sel;
    logic [2:0] qualifier;
  } mcd_region_type;

  // Whole state of the top module apart from the two reset synchronizer flops
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] three_upper;
    logic [7:0] three_mask;
    logic [7:0] four_upper;
    logic [7:0] four_mask;
    logic [7:0] qual;
    logic [7:0] pin_map;
    logic [1:0] act_en;
    logic [7:0] rdata;
    logic [NUM_PINS-1:0] cs_n;
    logic [1:0] activity;
    logic [1:0] wide;
    logic [1:0] hit;
  } mcd_state_type;

endpackage

// ==== design/mcd_region_decode.sv ====
// One memory range decoder: address compare, qualifier and cycle width
`timescale 1ns/1ps

module mcd_region_decode (
  // Settings
  input wire mcd_pkg::mcd_region_type i_cfg,
  // ISA cycle
  input wire mcd_pkg::mcd_isa_type i_isa,
  // Result
  output logic o_hit,
  output logic o_wide
);

  logic addr_match;
  logic qual_ok;

  // Masked low compare plus full upper compare
  always_comb begin
    // cleared compare bit drops the line
    // upper and unmasked low bits match
    addr_match = (i_isa.sa[25:18] == i_cfg.upper) &&
                 (((i_isa.sa[17:14] ^ i_cfg.low_match) & i_cfg.compare) == 4'h0);
  end

  // Strobe or address-valid qualification
  always_comb begin
    // address-valid gating, reserved codes never hit
    unique case (i_cfg.qualifier)
      mcd_pkg::Q_ADDR_ONLY: qual_ok = 1'b1;
      mcd_pkg::Q_READ: qual_ok = !i_isa.memr_n;
      mcd_pkg::Q_WRITE: qual_ok = !i_isa.memw_n;
      mcd_pkg::Q_EITHER: qual_ok = !i_isa.memr_n || !i_isa.memw_n;
      mcd_pkg::Q_CPU_VALID: qual_ok = i_isa.cpu_addr_valid;
      default: qual_ok = 1'b0;
    endcase
  end

  // Hit and width outputs
  always_comb begin
    o_hit = addr_match && qual_ok;
    // target's 16-bit request overrides width bit
    o_wide = i_cfg.wide_sel || !i_isa.mcs16_n;
  end

endmodule

// ==== design/mcd_range_select.sv ====
// Top of the memory range chip-select decoders with indexed registers
`timescale 1ns/1ps

// What this block does
// - Compare bits choose which SA17-14 lines count
// - Range four low nibble holds SA17-14 match
// - Range three low nibble holds SA17-14 match
// - Qual bit 7 picks range four width
// - Qual bit 3 picks range three width
// - Target 16-bit request forces 16-bit cycle
// - Range four qualifier: address, read, write, either
// - Code 100 gates by address valid; rest reserved
// - Range three qualifier bits 2-0, same codes
// - Hit drives pin only when mapped
// - Activity to power unit only when enabled
// - Nibble picks pin 0-14, all ones disables
module mcd_range_select (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Indexed configuration port
  input wire logic [15:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  output logic [7:0] o_io_rdata,
  // ISA memory cycle
  input wire mcd_pkg::mcd_isa_type i_isa,
  // Chip selects and activity
  output logic [mcd_pkg::NUM_PINS-1:0] o_gpio_cs_n,
  output logic [1:0] o_pm_activity,
  output logic [1:0] o_cycle_16bit,
  output logic [1:0] o_range_hit
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and decoders
  mcd_pkg::mcd_state_type s;
  mcd_pkg::mcd_state_type next_s;
  mcd_pkg::mcd_region_type cfg [2];
  logic [1:0] region_hit;
  logic [1:0] region_wide;
  logic [7:0] reg_value;

  // Pin decode, used for both ranges
  function automatic logic pin_hit(input logic hit, input logic [3:0] sel, input int pin);
    pin_hit = hit && (sel != mcd_pkg::PIN_DISABLED) && (sel == 4'(pin));
  endfunction

  // Region 0 is range three, region 1 is range four
  always_comb begin
    // range three compare and low match
    cfg[0].upper = s.three_upper;
    cfg[0].compare = s.three_mask[7:4];
    cfg[0].low_match = s.three_mask[3:0];
    cfg[0].wide_sel = s.qual[mcd_pkg::THREE_WIDTH_BIT];
    cfg[0].qualifier = s.qual[2:0];
    // range four compare and low match
    cfg[1].upper = s.four_upper;
    cfg[1].compare = s.four_mask[7:4];
    cfg[1].low_match = s.four_mask[3:0];
    cfg[1].wide_sel = s.qual[mcd_pkg::FOUR_WIDTH_BIT];
    cfg[1].qualifier = s.qual[6:4];
  end

  for (genvar r = 0; r < 2; r++) begin : g_region
    mcd_region_decode u_dec (
      .i_cfg(cfg[r]),
      .i_isa(i_isa),
      .o_hit(region_hit[r]),
      .o_wide(region_wide[r])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux; unmapped indexes read zero
  always_comb begin
    unique case (s.index)
      mcd_pkg::IDX_PIN_MAP: reg_value = s.pin_map;
      mcd_pkg::IDX_THREE_UPPER: reg_value = s.three_upper;
      mcd_pkg::IDX_THREE_MASK: reg_value = s.three_mask;
      mcd_pkg::IDX_FOUR_UPPER: reg_value = s.four_upper;
      mcd_pkg::IDX_FOUR_MASK: reg_value = s.four_mask;
      mcd_pkg::IDX_QUAL: reg_value = s.qual;
      mcd_pkg::IDX_ACT_EN: reg_value = {4'h0, s.act_en, 2'h0};
      default: reg_value = 8'h00;
    endcase
  end

  // Next state: register port, then decode outputs
  always_comb begin
    next_s = s;
    if (i_io_wr && (i_io_addr == mcd_pkg::INDEX_PORT)) begin
      next_s.index = i_io_wdata;
    end
    if (i_io_wr && (i_io_addr == mcd_pkg::DATA_PORT)) begin
      unique case (s.index)
        mcd_pkg::IDX_PIN_MAP: next_s.pin_map = i_io_wdata;
        mcd_pkg::IDX_THREE_UPPER: next_s.three_upper = i_io_wdata;
        mcd_pkg::IDX_THREE_MASK: next_s.three_mask = i_io_wdata;
        mcd_pkg::IDX_FOUR_UPPER: next_s.four_upper = i_io_wdata;
        mcd_pkg::IDX_FOUR_MASK: next_s.four_mask = i_io_wdata;
        mcd_pkg::IDX_QUAL: next_s.qual = i_io_wdata;
        mcd_pkg::IDX_ACT_EN: begin
          next_s.act_en = {i_io_wdata[mcd_pkg::ACT_FOUR_BIT],
                           i_io_wdata[mcd_pkg::ACT_THREE_BIT]};
        end
        default: next_s.index = s.index;
      endcase
    end
    // Read data holds until the next read strobe
    if (i_io_rd) begin
      if (i_io_addr == mcd_pkg::INDEX_PORT) begin
        next_s.rdata = s.index;
      end else if (i_io_addr == mcd_pkg::DATA_PORT) begin
        next_s.rdata = reg_value;
      end else begin
        next_s.rdata = 8'h00;
      end
    end
    next_s.hit = region_hit;
    // Width only meaningful while the range hits
    next_s.wide = region_hit & region_wide;
    // address-only code may give false activity here
    next_s.activity = region_hit & s.act_en;
    // drive a pin only when mapped
    // nibble picks pin, all ones disables
    for (int p = 0; p < mcd_pkg::NUM_PINS; p++) begin
      next_s.cs_n[p] = !(pin_hit(region_hit[0], s.pin_map[3:0], p) ||
                         pin_hit(region_hit[1], s.pin_map[7:4], p));
    end
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      s.index <= mcd_pkg::RST_INDEX;
      s.three_upper <= mcd_pkg::RST_UPPER;
      s.three_mask <= mcd_pkg::RST_MASK;
      s.four_upper <= mcd_pkg::RST_UPPER;
      s.four_mask <= mcd_pkg::RST_MASK;
      s.qual <= mcd_pkg::RST_QUAL;
      s.pin_map <= mcd_pkg::RST_PIN_MAP;
      s.act_en <= mcd_pkg::RST_ACT_EN;
      s.rdata <= 8'h00;
      s.cs_n <= '1;
      s.activity <= 2'h0;
      s.wide <= 2'h0;
      s.hit <= 2'h0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops
  assign o_io_rdata = s.rdata;
  assign o_gpio_cs_n = s.cs_n;
  assign o_pm_activity = s.activity;
  assign o_cycle_16bit = s.wide;
  assign o_range_hit = s.hit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_act_gate: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    o_pm_activity[1] |-> $past(s.act_en[1]) && $past(region_hit[1]))
    else $error("activity without enable or hit");
  a_act_pass: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (region_hit[0] && s.act_en[0]) |=> o_pm_activity[0])
    else $error("enabled hit gave no activity");
  a_pin_off: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (s.pin_map == 8'hFF) |=> (o_gpio_cs_n == '1))
    else $error("pin driven while unmapped");
  a_pin_drive: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (region_hit[0] && s.pin_map[3:0] == 4'h2) |=> !o_gpio_cs_n[2])
    else $error("mapped pin not driven");
  a_wide_mcs16: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (region_hit[0] && !i_isa.mcs16_n) |=> o_cycle_16bit[0])
    else $error("16-bit request ignored");
  a_width_four: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (region_hit[1] && i_isa.mcs16_n) |=> (o_cycle_16bit[1] == $past(s.qual[7])))
    else $error("range four width wrong");
  a_width_three: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (region_hit[0] && i_isa.mcs16_n) |=> (o_cycle_16bit[0] == $past(s.qual[3])))
    else $error("range three width wrong");
  a_qual_read: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (s.qual[6:4] == 3'h1 && i_isa.memr_n) |=> !o_range_hit[1])
    else $error("read qualifier not applied");
  a_qual_cav: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (s.qual[2:0] == 3'h4 && !i_isa.cpu_addr_valid) |=> !o_range_hit[0])
    else $error("address valid not applied");
  a_mask_excl: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (s.three_mask[7:4] == 4'h0 && s.qual[2:0] == 3'h0 &&
     i_isa.sa[25:18] == s.three_upper) |=> o_range_hit[0])
    else $error("masked lines still compared");
  a_low_match: assert property (@(posedge i_ref_clk) disable iff (!rst_sync)
    (s.four_mask[7:4] == 4'hF && i_isa.sa[17:14] != s.four_mask[3:0]) |=> !o_range_hit[1])
    else $error("range four low mismatch hit");

endmodule

// ==== bench/mcd_isa_target.sv ====
// Behavioural ISA memory target on the far side of the range decoders
`timescale 1ns/1ps

module mcd_isa_target #(
  parameter logic [7:0] UPPER = 8'h5A
) (
  // Address seen on the bus
  input wire logic [25:14] i_sa,
  input wire logic i_wide,
  // Open-collector width request
  output logic o_mcs16_n
);
  // target width request
  // Pulled up when not addressed, so a released line reads high
  assign o_mcs16_n = !(i_wide && (i_sa[25:18] == UPPER));
endmodule

// ==== bench/mcd_range_select_bench.sv ====
// Self-checking bench for the memory range chip-select decoders
`timescale 1ns/1ps

module mcd_range_select_bench;
  typedef struct {int due; logic [20:0] exp; bit rd;} mcd_note_type;
  localparam logic [7:0] PEER_UP = 8'h5A;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [25:14] sa = '0;
  logic [3:0] strb = 4'h0;
  logic [7:0] io_rdata;
  logic mcs16_n;
  logic [14:0] cs_n;
  logic [1:0] act, w16, hit;
  mcd_pkg::mcd_isa_type isa;
  logic [7:0] sh [logic [7:0]];
  logic [7:0] ix [8] = '{8'hB3, 8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'h60, 8'h55};
  int seed = 13;
  int cyc = 0;
  int err_count = 0;
  int compares = 0;
  mcd_note_type q[$];

  ////////////////////////////////////////////////////////////////////////////
  // Strobe bits: read, write, address valid, peer width request
  assign isa = '{sa: sa, memr_n: strb[3], memw_n: strb[2], cpu_addr_valid: strb[1],
                 mcs16_n: mcs16_n};

  mcd_range_select i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_io_addr(io_addr),
    .i_io_wdata(io_wdata), .i_io_wr(io_wr), .i_io_rd(io_rd), .o_io_rdata(io_rdata),
    .i_isa(isa), .o_gpio_cs_n(cs_n), .o_pm_activity(act), .o_cycle_16bit(w16),
    .o_range_hit(hit));
  mcd_isa_target #(.UPPER(PEER_UP)) i_peer (.i_sa(sa), .i_wide(strb[0]), .o_mcs16_n(mcs16_n));

  always #20 i_ref_clk = ~i_ref_clk;

  // Cycle count; the ceiling is far above the planned run
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Monitor: outputs settle just after the edge a note is due
  always @(posedge i_ref_clk) begin
    #1;
    while (q.size() > 0 && q[0].due == cyc) begin
      if (q[0].rd) begin
        check({13'h0, io_rdata}, q[0].exp);
      end else begin
        check({hit, w16, act, cs_n}, q[0].exp);
      end
      void'(q.pop_front());
    end
  end

  task automatic io(input logic [15:0] a, input logic [7:0] d, input bit w, input bit r);
    @(posedge i_ref_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= r;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    io(mcd_pkg::INDEX_PORT, idx, 1, 0);
    io(mcd_pkg::DATA_PORT, v, 1, 0);
    io(16'h0000, 8'h00, 0, 0);
    if (sh.exists(idx)) sh[idx] = (idx == mcd_pkg::IDX_ACT_EN) ? (v & 8'h0C) : v;
  endtask

  task automatic rd(input logic [7:0] idx);
    io(mcd_pkg::INDEX_PORT, idx, 1, 0);
    io(mcd_pkg::DATA_PORT, 8'h00, 0, 1);
    // Strobe is sampled one edge later and the data stands after it
    q.push_back('{cyc + 2, sh.exists(idx) ? 21'(sh[idx]) : 21'h0, 1});
    io(16'h0000, 8'h00, 0, 0);
  endtask

  // Reference decode from the shadow registers
  function automatic logic [20:0] expect_dec(input logic [25:14] a, input logic [3:0] s);
    logic [1:0] h, w, e;
    logic [14:0] c;
    logic [7:0] up, mk, qr;
    logic [3:0] pin;
    c = '1;
    qr = sh[mcd_pkg::IDX_QUAL];
    for (int r = 0; r < 2; r++) begin
      up = sh[r ? mcd_pkg::IDX_FOUR_UPPER : mcd_pkg::IDX_THREE_UPPER];
      mk = sh[r ? mcd_pkg::IDX_FOUR_MASK : mcd_pkg::IDX_THREE_MASK];
      h[r] = a[25:18] == up && ((a[17:14] ^ mk[3:0]) & mk[7:4]) == 4'h0;
      case (qr[4*r +: 3])
        3'h0: ;
        3'h1: h[r] &= !s[3];
        3'h2: h[r] &= !s[2];
        3'h3: h[r] &= !(s[3] && s[2]);
        3'h4: h[r] &= s[1];
        default: h[r] = 1'b0;
      endcase
      w[r] = h[r] && (qr[4*r+3] || (s[0] && a[25:18] == PEER_UP));
      pin = sh[mcd_pkg::IDX_PIN_MAP][4*r +: 4];
      if (h[r] && pin != 4'hF) c[pin] = 1'b0;
      e[r] = h[r] && sh[mcd_pkg::IDX_ACT_EN][2+r];
    end
    return {h, w, e, c};
  endfunction

  // Aim the address at either range, the peer or nowhere in particular
  task automatic cycle_isa();
    logic [7:0] up;
    logic [25:14] a;
    logic [3:0] s;
    case ($random(seed) & 3)
      0: up = sh[mcd_pkg::IDX_THREE_UPPER];
      1: up = sh[mcd_pkg::IDX_FOUR_UPPER];
      2: up = PEER_UP;
      default: up = 8'($random(seed));
    endcase
    a = {up, 4'($random(seed))};
    s = 4'($random(seed));
    @(posedge i_ref_clk);
    sa <= a;
    strb <= s;
    // Inputs are sampled at the next edge, outputs registered there
    q.push_back('{cyc + 2, expect_dec(a, s), 0});
  endtask

  task automatic complete_run();
    // A note never taken off the queue counts as a miss
    if (q.size() != 0) err_count++;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    foreach (ix[i]) if (i < 7) sh[ix[i]] = 8'h00;
    sh[mcd_pkg::IDX_PIN_MAP] = 8'hFF;
    repeat (5) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    // Reset values, then random write and read back, unmapped index too
    foreach (ix[i]) rd(ix[i]);
    foreach (ix[i]) wr(ix[i], 8'($random(seed)));
    foreach (ix[i]) rd(ix[i]);
    repeat (2) @(posedge i_ref_clk);
    $display("Register test done");
    // Every qualifier code for both ranges, random settings otherwise
    for (int i = 0; i < 64; i++) begin
      for (int k = 1; k < 6; k++) wr(ix[k], 8'($random(seed)));
      // mapped pins taken as already set up as outputs
      wr(mcd_pkg::IDX_PIN_MAP, 8'($random(seed)));
      wr(mcd_pkg::IDX_QUAL, {1'($random(seed)), 3'(i % 8), 1'($random(seed)), 3'(i / 8)});
      // activity left off while address-only code is set
      wr(mcd_pkg::IDX_ACT_EN, (i % 8 != 0 && i / 8 != 0) ? 8'($random(seed)) : 8'h00);
      repeat (6) cycle_isa();
    end
    repeat (2) @(posedge i_ref_clk);
    $display("Decode test done");
    complete_run();
  end
endmodule
